// ---- hw/home_search_pkg.sv ----
/*
  Shared constants and carrier types for the automatic home search sequencer.
  Assumes a 40 MHz system clock and an APB master with 32-bit data.
*/
`default_nettype none
package home_search_pkg;

  // Register byte addresses on APB.
  localparam logic [7:0] ADDR_COMMAND     = 8'h00;
  localparam logic [7:0] ADDR_INPUT_MODE  = 8'h04;
  localparam logic [7:0] ADDR_MODE_DATA   = 8'h08;
  localparam logic [7:0] ADDR_HIGH_SPEED  = 8'h0c;
  localparam logic [7:0] ADDR_HOME_SPEED  = 8'h10;
  localparam logic [7:0] ADDR_INIT_SPEED  = 8'h14;
  localparam logic [7:0] ADDR_OFFSET_CNT  = 8'h18;
  localparam logic [7:0] ADDR_MAIN_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_ERROR_STAT  = 8'h20;
  localparam logic [7:0] ADDR_REAL_POS    = 8'h24;

  // Command codes.
  localparam logic [7:0] CMD_HIGH_SPEED = 8'h05;
  localparam logic [7:0] CMD_DEC_STOP   = 8'h26;
  localparam logic [7:0] CMD_INST_STOP  = 8'h27;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h25;
  localparam logic [7:0] CMD_SET_MODE   = 8'h60;
  localparam logic [7:0] CMD_HOME_SPEED = 8'h61;
  localparam logic [7:0] CMD_START_HOME = 8'h62;
  localparam logic [7:0] CMD_DEV_CLEAR  = 8'h63;

  // Input mode register fields.
  localparam int IDX_POLARITY_BIT = 4;
  localparam int IDX_ENABLE_BIT   = 5;
  localparam int IDX_CLEAR_BIT    = 6;

  // Mode data register fields.
  localparam int POST_CLEAR_BIT   = 8;
  localparam int AND_COND_BIT     = 9;
  localparam int CLR_ENABLE_BIT   = 11;
  localparam int CLR_POLARITY_BIT = 12;
  localparam int CLR_WIDTH_LSB    = 13;

  // Error status bits.
  localparam int ERR_LIMIT_POS_BIT = 2;
  localparam int ERR_LIMIT_NEG_BIT = 3;
  localparam int ERR_INDEX_BIT     = 7;

  // Reset values.
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // Clock rate and clearing pulse widths in microseconds.
  localparam int CLOCK_HZ = 40_000_000;
  localparam int CLR_WIDTH_US [8] = '{10, 20, 100, 200, 1000, 2000, 10000, 20000};

  // Step codes as reported in the error status register.
  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00000,
    ST_STEP1    = 5'b00011,
    ST_S2_REV_A = 5'b01000,
    ST_S2_REV_I = 5'b01001,
    ST_STEP2    = 5'b01111,
    ST_STEP3    = 5'b10100,
    ST_CLR      = 5'b10101,
    ST_STEP4    = 5'b11001,
    ST_SINGLE   = 5'b11010
  } step_e;

  // Motion request handed to the pulse generator.
  typedef struct packed {
    logic        run;
    logic        dir_neg;
    logic        accel;
    logic        inst_stop;
    logic [15:0] speed;
  } motion_s;

endpackage
`default_nettype wire

// ---- hw/auto_home_search_sequencer.sv ----
/*
  Automatic home search sequencer for one axis, with APB registers.
  Assumes synchronous sensor inputs and an external pulse generator that
  reports pulses and offset completion.
*/
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module auto_home_search_sequencer
  import home_search_pkg::*;
#(
  parameter int CLR_SCALE = 1   // Divides pulse widths for simulation.
)(
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic        o_pready,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pslverr,
  input  wire logic        i_near_home_input,
  input  wire logic        i_home_input,
  input  wire logic        i_encoder_index_input,
  input  wire logic        i_limit_pos,
  input  wire logic        i_limit_neg,
  input  wire logic        i_encoder_step,
  input  wire logic        i_encoder_dir_neg,
  input  wire logic        i_offset_done,
  output var  motion_s     o_motion,
  output var  logic        o_deviation_clear_output,
  output var  logic        o_logic_counter_clear
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Cycles for a width code; widths are minimum times, so round up.
  function automatic logic [31:0] clr_cycles(input logic [2:0] code);
    logic [63:0] c;
    c = (64'(CLR_WIDTH_US[code]) * 64'(CLOCK_HZ) + 64'd999_999) / 64'd1_000_000;
    c = c / 64'(CLR_SCALE);
    clr_cycles = (c == 64'd0) ? 32'd1 : c[31:0];
  endfunction

  // Level of the clear output when inactive or active.
  function automatic logic clr_level(input logic active, input logic low_act);
    clr_level = active ^ low_act;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    step_e       step;
    logic [15:0] input_mode;   // Input mode register.
    logic [15:0] mode_data;    // Staging mode data register.
    logic [15:0] home_mode;    // Mode latched by command 60h.
    logic [15:0] high_speed;
    logic [15:0] home_speed;
    logic [15:0] init_speed;
    logic [15:0] staged;       // Speed data waiting for 05 or 61.
    logic [7:0]  error_stat;
    logic        busy;
    logic [31:0] real_pos;
    logic        idx_prev;     // Index active level one cycle ago.
    logic        home_prev;
    logic [31:0] clr_cnt;
    logic        saw_home;     // Never set by the sequencer; holds its reset value of zero.
    logic        entered;      // First cycle of a step already seen.
    logic        pready;
    logic [31:0] prdata;
    motion_s     motion;
    logic        dcc;
    logic        lclr;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic idx_active;   // Index at its chosen active level, when enabled.
  logic lim_dir;      // Limit in the current step's direction.
  logic dir_neg;      // Direction of the current step.
  logic wr_take;      // APB write taken this cycle.
  logic slow_ramp;    // Home speed not below the initial speed, so the slow steps ramp.
  logic [7:0] cmd;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // All behaviour is in this one process so every flop has one driver.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.lclr = 1'b0;
    cmd = i_pwdata[7:0];
    // Index qualifies only when enabled; polarity chooses the level.
    idx_active = st_r.input_mode[IDX_ENABLE_BIT] &&
                 (i_encoder_index_input == st_r.input_mode[IDX_POLARITY_BIT]);
    st_nxt.idx_prev = idx_active;
    st_nxt.home_prev = i_home_input;

    // Step direction from the odd mode bits.
    case (st_r.step)
      ST_STEP1: dir_neg = st_r.home_mode[7];
      ST_STEP2, ST_S2_REV_A, ST_S2_REV_I: dir_neg = st_r.home_mode[5];
      ST_STEP3: dir_neg = st_r.home_mode[3];
      default:  dir_neg = st_r.home_mode[1];
    endcase
    lim_dir = dir_neg ? i_limit_neg : i_limit_pos;
    // A home speed below the initial speed runs flat and stops at once.
    slow_ramp = st_r.home_speed >= st_r.init_speed;

    // Encoder counting.
    if (i_encoder_step)
    begin
      st_nxt.real_pos = i_encoder_dir_neg ? st_r.real_pos - 32'd1 : st_r.real_pos + 32'd1;
    end
    // Only the index edge clears; a level already active at configuration
    // clears too, because the edge is taken from the qualified level.
    if (st_r.input_mode[IDX_CLEAR_BIT] && idx_active && !st_r.idx_prev)
    begin
      st_nxt.real_pos = 32'h0000_0000;
    end

    // APB: one wait state; access phase answered in its second cycle.
    wr_take = i_psel && i_penable && i_pwrite && !st_r.pready;
    st_nxt.pready = i_psel && i_penable && !st_r.pready;
    if (i_psel && i_penable && !i_pwrite && !st_r.pready)
    begin
      case (i_paddr)
        ADDR_INPUT_MODE:  st_nxt.prdata = {16'h0000, st_r.input_mode};
        ADDR_MODE_DATA:   st_nxt.prdata = {16'h0000, st_r.home_mode};
        ADDR_MAIN_STATUS: st_nxt.prdata = {30'h0, st_r.error_stat != 8'h00, st_r.busy};
        ADDR_ERROR_STAT:  st_nxt.prdata = {19'h0, st_r.step, st_r.error_stat};
        ADDR_REAL_POS:    st_nxt.prdata = st_r.real_pos;
        default:          st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    else if (!st_nxt.pready)
    begin
      st_nxt.prdata = 32'h0000_0000;
    end

    // Motion defaults: constant speed, stopped.
    st_nxt.motion = '0;

    // Sequencer.
    case (st_r.step)
      ST_IDLE:
      begin
        st_nxt.entered = 1'b0;
      end
      ST_STEP1:
      begin
        if (!st_r.home_mode[6] || i_near_home_input || lim_dir)
        begin
          st_nxt.step = ST_STEP2;
          st_nxt.entered = 1'b0;
        end
        else
        begin
          // High speed with acceleration; near-home gives decelerating stop.
          st_nxt.motion = '{1'b1, dir_neg, 1'b1, 1'b0, st_r.high_speed};
        end
      end
      ST_STEP2:
      begin
        st_nxt.entered = 1'b1;
        if (!st_r.home_mode[4])
        begin
          st_nxt.step = ST_STEP3;
          st_nxt.entered = 1'b0;
        end
        else if (!st_r.entered && i_home_input)
        begin
          st_nxt.step = ST_S2_REV_I;
        end
        else if (lim_dir)
        begin
          st_nxt.step = ST_S2_REV_A;
        end
        else if (i_home_input)
        begin
          st_nxt.step = ST_STEP3;
          st_nxt.entered = 1'b0;
        end
        else
        begin
          // Home speed; ramped when slow_ramp, else constant with an instant stop.
          st_nxt.motion = '{1'b1, dir_neg, slow_ramp, !slow_ramp, st_r.home_speed};
        end
      end
      ST_S2_REV_A:
      begin
        // Reverse until home activates.
        if (i_home_input)
        begin
          st_nxt.step = ST_S2_REV_I;
        end
        else
        begin
          st_nxt.motion = '{1'b1, !dir_neg, slow_ramp, !slow_ramp, st_r.home_speed};
        end
      end
      ST_S2_REV_I:
      begin
        // Keep reversing until home clears, then restart step two.
        if (!i_home_input)
        begin
          st_nxt.step = ST_STEP2;
          st_nxt.entered = 1'b0;
        end
        else
        begin
          st_nxt.motion = '{1'b1, !dir_neg, slow_ramp, !slow_ramp, st_r.home_speed};
        end
      end
      ST_STEP3:
      begin
        st_nxt.entered = 1'b1;
        if (!st_r.home_mode[2])
        begin
          st_nxt.step = ST_STEP4;
          st_nxt.entered = 1'b0;
        end
        else if (!st_r.entered && idx_active)
        begin
          st_nxt.error_stat[ERR_INDEX_BIT] = 1'b1;
          st_nxt.step = ST_IDLE;
          st_nxt.busy = 1'b0;
        end
        else if (lim_dir)
        begin
          st_nxt.error_stat[dir_neg ? ERR_LIMIT_NEG_BIT : ERR_LIMIT_POS_BIT] = 1'b1;
          st_nxt.step = ST_IDLE;
          st_nxt.busy = 1'b0;
        end
        else if (idx_active && (!st_r.home_mode[AND_COND_BIT] || i_home_input))
        begin
          st_nxt.entered = 1'b0;
          if (st_r.home_mode[CLR_ENABLE_BIT])
          begin
            st_nxt.step = ST_CLR;
            st_nxt.clr_cnt = clr_cycles(st_r.home_mode[15:13]);
          end
          else
          begin
            st_nxt.step = ST_STEP4;
          end
        end
        else
        begin
          st_nxt.motion = '{1'b1, dir_neg, slow_ramp, !slow_ramp, st_r.home_speed};
        end
      end
      ST_CLR, ST_SINGLE:
      begin
        // Clear pulse held for the selected width.
        if (st_r.clr_cnt <= 32'd1)
        begin
          st_nxt.step = (st_r.step == ST_CLR) ? ST_STEP4 : ST_IDLE;
          st_nxt.clr_cnt = 32'd0;
        end
        else
        begin
          st_nxt.clr_cnt = st_r.clr_cnt - 32'd1;
        end
      end
      ST_STEP4:
      begin
        st_nxt.entered = 1'b1;
        if (!st_r.home_mode[0])
        begin
          st_nxt.step = ST_IDLE;
          st_nxt.busy = 1'b0;
        end
        else if (lim_dir)
        begin
          st_nxt.error_stat[dir_neg ? ERR_LIMIT_NEG_BIT : ERR_LIMIT_POS_BIT] = 1'b1;
          st_nxt.step = ST_IDLE;
          st_nxt.busy = 1'b0;
        end
        else if (st_r.entered && i_offset_done)
        begin
          st_nxt.step = ST_IDLE;
          st_nxt.busy = 1'b0;
          if (st_r.home_mode[POST_CLEAR_BIT])
          begin
            st_nxt.real_pos = 32'h0000_0000;
            st_nxt.lclr = 1'b1;
          end
        end
        else
        begin
          st_nxt.motion = '{1'b1, dir_neg, 1'b1, 1'b0, st_r.high_speed};
        end
      end
      default:
      begin
        st_nxt.step = ST_IDLE;
      end
    endcase

    // Register writes and commands; they follow the sequencer so a stop wins.
    if (wr_take)
    begin
      case (i_paddr)
        ADDR_INPUT_MODE: st_nxt.input_mode = i_pwdata[15:0];
        ADDR_MODE_DATA:  st_nxt.mode_data = i_pwdata[15:0];
        ADDR_HIGH_SPEED, ADDR_HOME_SPEED: st_nxt.staged = i_pwdata[15:0];
        ADDR_INIT_SPEED: st_nxt.init_speed = i_pwdata[15:0];
        ADDR_COMMAND:
        begin
          case (cmd)
            CMD_HIGH_SPEED: st_nxt.high_speed = st_r.staged;
            CMD_HOME_SPEED: st_nxt.home_speed = st_r.staged;
            CMD_SET_MODE:   st_nxt.home_mode = st_r.mode_data;
            CMD_CLR_STATUS: st_nxt.error_stat = 8'h00;
            CMD_START_HOME:
            begin
              st_nxt.step = ST_STEP1;
              st_nxt.busy = 1'b1;
              st_nxt.entered = 1'b0;
              st_nxt.error_stat = 8'h00;
            end
            CMD_DEV_CLEAR:
            begin
              if (st_r.step == ST_IDLE)
              begin
                st_nxt.step = ST_SINGLE;
                st_nxt.clr_cnt = clr_cycles(st_r.home_mode[15:13]);
              end
            end
            CMD_DEC_STOP, CMD_INST_STOP:
            begin
              st_nxt.step = ST_IDLE;
              st_nxt.busy = 1'b0;
              st_nxt.motion = '0;
            end
            default:
            begin
              st_nxt.busy = st_nxt.busy;
            end
          endcase
        end
        default:
        begin
          st_nxt.staged = st_nxt.staged;
        end
      endcase
    end

    // Clear output level from the chosen polarity.
    st_nxt.dcc = clr_level((st_nxt.step == ST_CLR) || (st_nxt.step == ST_SINGLE),
                           st_nxt.home_mode[CLR_POLARITY_BIT]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  // One register for the whole state; synchronous reset.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      st_r <= '0;
      st_r.step <= ST_IDLE;
      st_r.input_mode <= MODE_RESET;
      st_r.home_mode <= MODE_RESET;
      st_r.mode_data <= MODE_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_pready = st_r.pready;
  assign o_prdata = st_r.prdata;
  assign o_pslverr = 1'b0;
  assign o_motion = st_r.motion;
  assign o_deviation_clear_output = st_r.dcc;
  assign o_logic_counter_clear = st_r.lclr;

endmodule // auto_home_search_sequencer
`default_nettype wire

// ---- bench/home_search_properties.sv ----
/*
  Checker of the home search sequencer ports: APB answer, speeds, stops and clearing.
  Assumes commands sit in the low byte of a write to the command address.
*/
`timescale 1ns/1ps
`default_nettype none
module home_search_checker
  import home_search_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        o_pready,
  input  wire logic [31:0] o_prdata,
  input  wire logic        o_pslverr,
  input  wire motion_s     o_motion,
  input  wire logic        o_deviation_clear_output,
  input  wire logic        o_logic_counter_clear
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic [15:0] stage_r, fast_r;  // Speed staging and the committed high speed.
  logic        pol_nxt, pol_r;   // Staged and committed clear polarity.
  wire  logic  done = i_psel && i_penable && o_pready && i_pwrite;
  wire  logic  cmd  = done && i_paddr == ADDR_COMMAND;
  //////////////////////////////////////////////////////////////////////////////
  // Shadow the registers that decide speed and clear polarity.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      {stage_r, fast_r, pol_nxt, pol_r} <= '0;
    end
    else
    begin
      if (done && (i_paddr == ADDR_HIGH_SPEED || i_paddr == ADDR_HOME_SPEED))
        stage_r <= i_pwdata[15:0];
      if (done && i_paddr == ADDR_MODE_DATA)
        pol_nxt <= i_pwdata[CLR_POLARITY_BIT];
      if (cmd && i_pwdata[7:0] == CMD_HIGH_SPEED)
        fast_r <= stage_r;
      if (cmd && i_pwdata[7:0] == CMD_SET_MODE)
        pol_r <= pol_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  apb_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("access not answered after one wait state");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  rdata_quiet_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside an answer");
  no_slverr_a: assert property (o_pslverr == 1'b0)
    else $error("slave error raised");
  fast_speed_a: assert property ($rose(o_motion.run) && o_motion.accel |-> o_motion.speed == fast_r)
    else $error("accelerated step not at high speed");
  inst_stop_a: assert property (cmd && i_pwdata[7:0] == CMD_INST_STOP |-> ##[0:4] !o_motion.run)
    else $error("instant stop ignored");
  clear_idle_a: assert property ((o_deviation_clear_output ^ pol_r) |-> !o_motion.run)
    else $error("motion during clearing pulse");
  cnt_pulse_a: assert property (o_logic_counter_clear |=> !o_logic_counter_clear)
    else $error("counter clear longer than one cycle");
endmodule // home_search_checker
bind auto_home_search_sequencer home_search_checker u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_motion(o_motion),
  .o_deviation_clear_output(o_deviation_clear_output),
  .o_logic_counter_clear(o_logic_counter_clear));
`default_nettype wire

// ---- bench/home_search_partner.sv ----
/*
  Axis model: integrates the motion request into a position and derives the sensors.
  Assumes near-home at 40..54, home at 60..70, raw high index at positions equal to 7 modulo 16.
*/
`timescale 1ns/1ps
`default_nettype none
module home_search_partner
  import home_search_pkg::*;
#(
  parameter int DIV    = 6,   // Cycles per step; above 4 so the index stays long enough.
  parameter int OFFSET = 30   // Run cycles until the pulse generator reports offset done.
)(
  input  wire logic    i_clock,
  input  wire motion_s i_motion,
  output wire logic    o_near_home_input,
  output wire logic    o_home_input,
  output wire logic    o_encoder_index_input,
  output var  logic    o_encoder_step,
  output var  logic    o_encoder_dir_neg,
  output var  logic    o_offset_done
);
  int pos, tick, runlen;  // Axis position, step divider and length of the current run.
  initial
  begin
    {pos, tick, runlen} = '0;
    {o_encoder_step, o_encoder_dir_neg, o_offset_done} = '0;
  end
  // Sensors follow the position only; a stopped axis keeps them as they are.
  assign o_near_home_input     = pos >= 40 && pos <= 54;
  assign o_home_input          = pos >= 60 && pos <= 70;
  assign o_encoder_index_input = pos[3:0] == 4'h7;
  //////////////////////////////////////////////////////////////////////////////
  // One encoder count every DIV cycles of motion, in the requested direction.
  always @(posedge i_clock)
  begin
    o_encoder_step <= 1'b0;
    o_offset_done  <= 1'b0;
    if (!i_motion.run)
    begin
      {tick, runlen} <= '0;
    end
    else
    begin
      tick   <= (tick == DIV - 1) ? 0 : tick + 1;
      runlen <= runlen + 1;
      if (tick == 0)
      begin
        pos               <= pos + (i_motion.dir_neg ? -1 : 1);
        o_encoder_step    <= 1'b1;
        o_encoder_dir_neg <= i_motion.dir_neg;
      end
      if (runlen == OFFSET)
        o_offset_done <= 1'b1;
    end
  end
endmodule // home_search_partner
`default_nettype wire

// ---- bench/auto_home_search_sequencer_tb.sv ----
/*
  Self-checking bench: APB master, read results compared from a queue of notes.
  Assumes the partner model drives sensors, encoder and offset completion.
*/
`timescale 1ns/1ps
`default_nettype none
module auto_home_search_sequencer_tb;
  import home_search_pkg::*;
  localparam int SCALE = 10;  // Shortens clearing pulses; expectations use it too.
  logic        i_clock, i_sys_rst, psel, penable, pwrite, lim_pos, lim_neg;
  logic        pready, pslverr, dev_clr, cnt_clr, near, home, idx, estep, edir, odone;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [32:0] notes[$];  // Bit 32 set means the read is compared.
  logic [32:0] note;
  logic [15:0] rnd, hs, hv;
  motion_s     motion;
  int          errors, checked, clears;
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  auto_home_search_sequencer #(.CLR_SCALE(SCALE)) dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_near_home_input(near),
    .i_home_input(home), .i_encoder_index_input(idx), .i_limit_pos(lim_pos),
    .i_limit_neg(lim_neg), .i_encoder_step(estep), .i_encoder_dir_neg(edir),
    .i_offset_done(odone), .o_motion(motion), .o_deviation_clear_output(dev_clr),
    .o_logic_counter_clear(cnt_clr));
  home_search_partner far (
    .i_clock(i_clock), .i_motion(motion), .o_near_home_input(near), .o_home_input(home),
    .o_encoder_index_input(idx), .o_encoder_step(estep), .o_encoder_dir_neg(edir),
    .o_offset_done(odone));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge i_clock);
    {psel, pwrite, paddr} <= {1'b1, w, a};
    pwdata <= w ? d : 32'h0;
    if (!w)
      notes.push_back({c, d});
    @(posedge i_clock);
    penable <= 1'b1;
    // Waits as long as the answer takes; only the watchdog ends a hang.
    do
      @(posedge i_clock);
    while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, e, 1'b1);
  endtask
  task automatic mode(input logic [15:0] m);
    wr(ADDR_MODE_DATA, {16'h0, m});
    wr(ADDR_COMMAND, {24'h0, CMD_SET_MODE});
  endtask
  task automatic start;
    wr(ADDR_COMMAND, {24'h0, CMD_START_HOME});
  endtask
  // Polls the busy flag; gives up after 2000 polls.
  task automatic idle;
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 2000)
    begin
      bus(1'b0, ADDR_MAIN_STATUS, 32'h0, 1'b0);
      n++;
    end
  endtask
  // Measures one clearing pulse at the given active level, one cycle of slack.
  task automatic pulse(input logic act, input int i);
    int n, e;
    e = CLR_WIDTH_US[i] * (CLOCK_HZ / 1_000_000) / SCALE;
    n = 0;
    while (dev_clr !== act && n < 5000)
    begin
      @(posedge i_clock);
      n++;
    end
    n = 0;
    while (dev_clr === act)
    begin
      @(posedge i_clock);
      n++;
    end
    check({31'h0, n >= e - 1 && n <= e + 1}, 32'h1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Results appear as read answers; each takes the oldest note.
  always @(posedge i_clock)
    if (pready === 1'b1 && psel && !pwrite && notes.size() > 0)
    begin
      note = notes.pop_front();
      if (note[32])
        check(prdata, note[31:0]);
    end
  // Counts the pulses of the counter clear output.
  always @(posedge i_clock)
    if (cnt_clr === 1'b1)
      clears++;
  initial
  begin
    repeat (60000) @(posedge i_clock);
    errors++;
    end_of_test;
  end
  initial
  begin
    {psel, penable, pwrite, lim_pos, lim_neg, paddr, pwdata} = '0;
    {errors, checked, clears} = '0;
    rnd = 16'h0054;
    i_sys_rst = 1'b1;
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(ADDR_MODE_DATA, {16'h0, MODE_RESET});
    rd(ADDR_ERROR_STAT, 32'h0);
    rd(8'h30, 32'h0);
    rnd = lfsr(rnd);
    hs = {1'b1, rnd[14:0]};
    rnd = lfsr(rnd);
    hv = {8'h0, rnd[7:0] | 8'h01};
    wr(ADDR_INIT_SPEED, 32'h100);
    wr(ADDR_HIGH_SPEED, {16'h0, hs});
    wr(ADDR_COMMAND, {24'h0, CMD_HIGH_SPEED});
    wr(ADDR_HOME_SPEED, {16'h0, hv});
    wr(ADDR_COMMAND, {24'h0, CMD_HOME_SPEED});
    wr(ADDR_INPUT_MODE, 32'h70);
    // Steps one to three forward with a clearing pulse; step four skipped.
    mode(16'h0854);
    start;
    pulse(1'b1, 0);
    idle;
    rd(ADDR_REAL_POS, 32'h0);
    rd(ADDR_ERROR_STAT, 32'h0);
    // Step one backwards, cut short by an instant stop.
    mode(16'h00c0);
    start;
    repeat (20) @(posedge i_clock);
    wr(ADDR_COMMAND, {24'h0, CMD_INST_STOP});
    idle;
    // Index made active by a polarity change clears the moved counter.
    wr(ADDR_INPUT_MODE, 32'h60);
    rd(ADDR_REAL_POS, 32'h0);
    mode(16'h0014);
    start;
    idle;
    rd(ADDR_ERROR_STAT, 32'h80);
    wr(ADDR_INPUT_MODE, 32'h70);
    // Offset step alone, counters cleared at its end.
    mode(16'h0101);
    start;
    idle;
    rd(ADDR_REAL_POS, 32'h0);
    check(32'(clears), 32'h1);
    for (int d = 0; d < 2; d++)
    begin
      {lim_neg, lim_pos} <= d ? 2'b10 : 2'b01;
      mode(16'h0004 | 16'(d << 3));
      start;
      idle;
      rd(ADDR_ERROR_STAT, 32'(1 << (ERR_LIMIT_POS_BIT + d)));
    end
    {lim_neg, lim_pos} <= 2'b00;
    mode(16'h3800);
    wr(ADDR_COMMAND, {24'h0, CMD_DEV_CLEAR});
    pulse(1'b0, 1);
    end_of_test;
  end
endmodule // auto_home_search_sequencer_tb
`default_nettype wire
